// ==== hdl/compensation_settings_cmds.sv ====
// Functional notes
// - Offset and altitude get/set only act while idle; pressure set also allowed while measuring, but not during the stop hold-off.
// - Settings are volatile; reset restores the default values.
// - Temperature offset alters temperature and humidity outputs only, never gas output.
// - Temperature offset defaults to the word for four degrees Celsius.
// - Command 0x241d sets offset word (deg*65536/175), quick, no reply.
// - Command 0x2318 returns offset word plus checksum, three bytes.
// - Altitude defaults to zero metres.
// - Command 0x2427 sets altitude word in metres, no reply.
// - Command 0x2322 returns altitude word in metres plus checksum.
// - Ambient pressure command is accepted during periodic measurement.
// - Command 0xe000 sets pressure word (pascal/100), no reply.
// - Once pressure is written it replaces altitude-based pressure compensation.
// - Command 0x3f86 stops measurement; commands ignored for 500 ms afterwards.
// - Command 0x21b1 starts measurement with a refresh every 5 seconds.
//
// Our own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`include "comp_consts.svh"

module compensation_settings_cmds #(
  parameter int unsigned STOP_CYCLES = `STOP_WAIT_MS * (`CLK_HZ / `MS_PER_S),
  parameter int unsigned PERIOD_CYCLES = `PERIOD_S * `CLK_HZ,
  parameter logic [6:0] LINK_ADDR = `LINK_ADDR,
  parameter logic [15:0] RH_GAIN = `RH_GAIN_Q8
) (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic [5:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_N_O
);

  comp_pkg::link_evt_t evt;
  comp_pkg::settings_t set_q, next_set;
  comp_pkg::byte_phase_t phase, next_phase;
  logic [15:0] cmd, next_cmd, par, next_par, resp, next_resp;
  logic resp_valid, next_resp_valid;
  logic [1:0] tx_idx, next_tx_idx;
  logic measuring, next_measuring, refresh, next_refresh, crc_err, next_crc_err;
  logic [31:0] stop_cnt, next_stop_cnt, period_cnt, next_period_cnt;
  logic [7:0] rx_crc, tx_crc, tx_byte;
  logic stop_busy;
  logic done, next_done;
  logic [31:0] rdata, next_rdata;
  logic [15:0] raw_t, next_raw_t, raw_rh, next_raw_rh, raw_co2, next_raw_co2;
  logic [15:0] t_out, rh_out, comp_val;
  logic [31:0] rh_prod;
  logic [16:0] rh_sum;
  logic bus_wr, clr_status;
  comp_pkg::cmd_kind_t kind_lo, kind_cmd;

  function automatic comp_pkg::cmd_kind_t cmd_kind(input logic [15:0] w);
    if (w == `CMD_SET_TOFFSET) begin
      return comp_pkg::CMD_SET_TOFF;
    end else if (w == `CMD_GET_TOFFSET) begin
      return comp_pkg::CMD_GET_TOFF;
    end else if (w == `CMD_SET_ALT) begin
      return comp_pkg::CMD_SET_ALT;
    end else if (w == `CMD_GET_ALT) begin
      return comp_pkg::CMD_GET_ALT;
    end else if (w == `CMD_SET_PRESS) begin
      return comp_pkg::CMD_SET_PRESS;
    end else if (w == `CMD_STOP_MEAS) begin
      return comp_pkg::CMD_STOP;
    end else if (w == `CMD_START_MEAS) begin
      return comp_pkg::CMD_START;
    end else begin
      return comp_pkg::CMD_NONE;
    end
  endfunction

  i2c_byte_target #(
    .ADDR(LINK_ADDR)
  ) u_link (
    .clk_i(CLK_I),
    .rst_i(RESET_I),
    .scl_i(SCL_I),
    .sda_i(SDA_I),
    .accept_i(~stop_busy),
    .read_ok_i(resp_valid),
    .tx_byte_i(tx_byte),
    .sda_oe_n_o(SDA_OE_N_O),
    .evt_o(evt)
  );

  crc8_unit u_rx_crc (
    .clk_i(CLK_I),
    .rst_i(RESET_I),
    .word_i(par),
    .crc_o(rx_crc)
  );

  crc8_unit u_tx_crc (
    .clk_i(CLK_I),
    .rst_i(RESET_I),
    .word_i(resp),
    .crc_o(tx_crc)
  );

  assign stop_busy = (stop_cnt != 32'h0);
  assign SDA_O = 1'b0;

  always_comb begin
    if (tx_idx == 2'h0) begin
      tx_byte = resp[15:8];
    end else if (tx_idx == 2'h1) begin
      tx_byte = resp[7:0];
    end else if (tx_idx == 2'h2) begin
      tx_byte = tx_crc;
    end else begin
      tx_byte = `FILL_BYTE;
    end
  end

  assign kind_lo = cmd_kind({cmd[15:8], evt.rx_byte});
  assign kind_cmd = cmd_kind(cmd);
  assign bus_wr = AVS_WRITE_I & done;
  assign clr_status = bus_wr && (AVS_ADDRESS_I == `REG_STATUS);

  always_comb begin
    next_set = set_q;
    next_phase = phase;
    next_cmd = cmd;
    next_par = par;
    next_resp = resp;
    next_resp_valid = resp_valid;
    next_tx_idx = tx_idx;
    next_measuring = measuring;
    next_refresh = refresh;
    next_crc_err = crc_err;
    next_stop_cnt = stop_cnt;
    next_period_cnt = period_cnt;
    // software clear first so that a same-cycle hardware set wins
    if (clr_status && AVS_WRITEDATA_I[`ST_REFRESH]) begin
      next_refresh = 1'b0;
    end
    if (clr_status && AVS_WRITEDATA_I[`ST_CRC_ERR]) begin
      next_crc_err = 1'b0;
    end
    if (stop_busy) begin
      next_stop_cnt = stop_cnt - 32'h1;
    end
    if (measuring) begin
      if (period_cnt == PERIOD_CYCLES - 32'h1) begin
        next_period_cnt = 32'h0;
        next_refresh = 1'b1;
      end else begin
        next_period_cnt = period_cnt + 32'h1;
      end
    end
    if (evt.addr) begin
      next_tx_idx = 2'h0;
      if (!evt.rw) begin
        next_phase = comp_pkg::B_CMD_HI;
        next_resp_valid = 1'b0;
      end
    end
    if (evt.tx_req && tx_idx != 2'h3) begin
      next_tx_idx = tx_idx + 2'h1;
    end
    if (evt.rx_valid) begin
      case (phase)
        comp_pkg::B_CMD_HI: begin
          next_cmd = {evt.rx_byte, 8'h00};
          next_phase = comp_pkg::B_CMD_LO;
        end
        comp_pkg::B_CMD_LO: begin
          next_cmd = {cmd[15:8], evt.rx_byte};
          next_phase = comp_pkg::B_DONE;
          if (measuring && kind_lo != comp_pkg::CMD_SET_PRESS && kind_lo != comp_pkg::CMD_STOP) begin
            next_phase = comp_pkg::B_DONE;
          end else begin
            case (kind_lo)
              comp_pkg::CMD_SET_TOFF, comp_pkg::CMD_SET_ALT, comp_pkg::CMD_SET_PRESS: begin
                next_phase = comp_pkg::B_PAR_HI;
              end
              comp_pkg::CMD_GET_TOFF: begin
                next_resp = set_q.toffset;
                next_resp_valid = 1'b1;
              end
              comp_pkg::CMD_GET_ALT: begin
                next_resp = set_q.altitude;
                next_resp_valid = 1'b1;
              end
              comp_pkg::CMD_STOP: begin
                next_measuring = 1'b0;
                next_stop_cnt = STOP_CYCLES;
              end
              comp_pkg::CMD_START: begin
                next_measuring = 1'b1;
                next_period_cnt = 32'h0;
              end
              default: begin
              end
            endcase
          end
        end
        comp_pkg::B_PAR_HI: begin
          next_par = {evt.rx_byte, par[7:0]};
          next_phase = comp_pkg::B_PAR_LO;
        end
        comp_pkg::B_PAR_LO: begin
          next_par = {par[15:8], evt.rx_byte};
          next_phase = comp_pkg::B_PAR_CRC;
        end
        comp_pkg::B_PAR_CRC: begin
          next_phase = comp_pkg::B_DONE;
          if (evt.rx_byte != rx_crc) begin
            next_crc_err = 1'b1;
          end else begin
            case (kind_cmd)
              comp_pkg::CMD_SET_TOFF: next_set.toffset = par;
              comp_pkg::CMD_SET_ALT: next_set.altitude = par;
              comp_pkg::CMD_SET_PRESS: begin
                next_set.pressure = par;
                next_set.press_set = 1'b1;
              end
              default: begin
              end
            endcase
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      set_q.toffset <= `TOFFSET_RESET;
      set_q.altitude <= `ALT_RESET;
      set_q.pressure <= `PRESS_RESET;
      set_q.press_set <= 1'b0;
      phase <= comp_pkg::B_DONE;
      cmd <= 16'h0000;
      par <= 16'h0000;
      resp <= 16'h0000;
      resp_valid <= 1'b0;
      tx_idx <= 2'h0;
      measuring <= 1'b0;
      refresh <= 1'b0;
      crc_err <= 1'b0;
      stop_cnt <= 32'h0;
      period_cnt <= 32'h0;
    end else begin
      set_q <= next_set;
      phase <= next_phase;
      cmd <= next_cmd;
      par <= next_par;
      resp <= next_resp;
      resp_valid <= next_resp_valid;
      tx_idx <= next_tx_idx;
      measuring <= next_measuring;
      refresh <= next_refresh;
      crc_err <= next_crc_err;
      stop_cnt <= next_stop_cnt;
      period_cnt <= next_period_cnt;
    end
  end

  // offset shifts temperature and humidity only
  assign t_out = (raw_t > set_q.toffset) ? raw_t - set_q.toffset : 16'h0000;
  assign rh_prod = set_q.toffset * RH_GAIN;
  assign rh_sum = {1'b0, raw_rh} + {1'b0, rh_prod[23:8]};
  assign rh_out = rh_sum[16] ? 16'hffff : rh_sum[15:0];
  assign comp_val = set_q.press_set ? set_q.pressure : set_q.altitude;

  // one wait cycle per access keeps the read mux off the critical path
  always_comb begin
    next_done = (AVS_READ_I | AVS_WRITE_I) & ~done;
    next_rdata = rdata;
    next_raw_t = raw_t;
    next_raw_rh = raw_rh;
    next_raw_co2 = raw_co2;
    if (AVS_READ_I && !done) begin
      if (AVS_ADDRESS_I == `REG_STATUS) begin
        next_rdata = {27'h0, crc_err, set_q.press_set, refresh, stop_busy, measuring};
      end else if (AVS_ADDRESS_I == `REG_TOFFSET) begin
        next_rdata = {16'h0, set_q.toffset};
      end else if (AVS_ADDRESS_I == `REG_ALT) begin
        next_rdata = {16'h0, set_q.altitude};
      end else if (AVS_ADDRESS_I == `REG_PRESS) begin
        next_rdata = {16'h0, set_q.pressure};
      end else if (AVS_ADDRESS_I == `REG_RAW_T) begin
        next_rdata = {16'h0, raw_t};
      end else if (AVS_ADDRESS_I == `REG_RAW_RH) begin
        next_rdata = {16'h0, raw_rh};
      end else if (AVS_ADDRESS_I == `REG_OUT_TRH) begin
        next_rdata = {rh_out, t_out};
      end else if (AVS_ADDRESS_I == `REG_CO2) begin
        next_rdata = {16'h0, raw_co2};
      end else if (AVS_ADDRESS_I == `REG_COMP) begin
        next_rdata = {15'h0, set_q.press_set, comp_val};
      end else begin
        next_rdata = 32'h0;
      end
    end
    if (bus_wr && AVS_ADDRESS_I == `REG_RAW_T) begin
      next_raw_t = AVS_WRITEDATA_I[15:0];
    end else if (bus_wr && AVS_ADDRESS_I == `REG_RAW_RH) begin
      next_raw_rh = AVS_WRITEDATA_I[15:0];
    end else if (bus_wr && AVS_ADDRESS_I == `REG_CO2) begin
      next_raw_co2 = AVS_WRITEDATA_I[15:0];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      done <= 1'b0;
      rdata <= 32'h0;
      raw_t <= 16'h0000;
      raw_rh <= 16'h0000;
      raw_co2 <= 16'h0000;
    end else begin
      done <= next_done;
      rdata <= next_rdata;
      raw_t <= next_raw_t;
      raw_rh <= next_raw_rh;
      raw_co2 <= next_raw_co2;
    end
  end

  assign AVS_READDATA_O = rdata;
  assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~done;

endmodule // compensation_settings_cmds

// ==== hdl/comp_consts.svh ====
`ifndef COMP_CONSTS_SVH
`define COMP_CONSTS_SVH

// command codes
`define CMD_SET_TOFFSET 16'h241d
`define CMD_GET_TOFFSET 16'h2318
`define CMD_SET_ALT 16'h2427
`define CMD_GET_ALT 16'h2322
`define CMD_SET_PRESS 16'he000
`define CMD_STOP_MEAS 16'h3f86
`define CMD_START_MEAS 16'h21b1

// reset values: offset word is 4 C * 65536 / 175, rounded
`define TOFFSET_RESET 16'h05da
`define ALT_RESET 16'h0000
`define PRESS_RESET 16'h0000

// timing
`define CLK_HZ 125000000
`define MS_PER_S 1000
`define STOP_WAIT_MS 500
`define PERIOD_S 5

// link and checksum
`define LINK_ADDR 7'h2a
`define CRC_POLY 8'h31
`define CRC_INIT 8'hff
`define FILL_BYTE 8'hff
`define RH_GAIN_Q8 16'h0100

// register byte offsets
`define REG_STATUS 6'h00
`define REG_TOFFSET 6'h04
`define REG_ALT 6'h08
`define REG_PRESS 6'h0c
`define REG_RAW_T 6'h10
`define REG_RAW_RH 6'h14
`define REG_OUT_TRH 6'h18
`define REG_CO2 6'h1c
`define REG_COMP 6'h20

// status bit positions
`define ST_MEAS 0
`define ST_STOP_BUSY 1
`define ST_REFRESH 2
`define ST_PRESS_SET 3
`define ST_CRC_ERR 4
`define COMP_SRC_BIT 16

`endif

// ==== hdl/comp_pkg.sv ====
package comp_pkg;

  typedef enum logic [2:0] {
    CMD_NONE, CMD_SET_TOFF, CMD_GET_TOFF, CMD_SET_ALT, CMD_GET_ALT,
    CMD_SET_PRESS, CMD_STOP, CMD_START
  } cmd_kind_t;

  typedef enum logic [2:0] {
    L_IDLE, L_RX, L_RX_END, L_RX_ACK, L_TX, L_TX_ACK
  } link_state_t;

  typedef enum logic [2:0] {
    B_CMD_HI, B_CMD_LO, B_PAR_HI, B_PAR_LO, B_PAR_CRC, B_DONE
  } byte_phase_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic addr;
    logic rw;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic tx_req;
  } link_evt_t;

  typedef struct packed {
    logic [15:0] toffset;
    logic [15:0] altitude;
    logic [15:0] pressure;
    logic press_set;
  } settings_t;

endpackage

// ==== hdl/crc8_unit.sv ====
`timescale 1ns/1ps
`include "comp_consts.svh"

module crc8_unit #(
  parameter logic [7:0] POLY = `CRC_POLY,
  parameter logic [7:0] INIT = `CRC_INIT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] word_i,
  output logic [7:0] crc_o
);

  logic [7:0] next_crc;

  function automatic logic [7:0] crc_word(input logic [15:0] w);
    logic [7:0] c;
    c = INIT;
    for (int i = 15; i >= 0; i--) begin
      if (c[7] ^ w[i]) begin
        c = {c[6:0], 1'b0} ^ POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction

  always_comb begin
    next_crc = crc_word(word_i);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      crc_o <= 8'h00;
    end else begin
      crc_o <= next_crc;
    end
  end

endmodule // crc8_unit

// ==== hdl/i2c_byte_target.sv ====
`timescale 1ns/1ps
`include "comp_consts.svh"

module i2c_byte_target #(
  parameter logic [6:0] ADDR = `LINK_ADDR
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic accept_i,
  input wire logic read_ok_i,
  input wire logic [7:0] tx_byte_i,
  output logic sda_oe_n_o,
  output comp_pkg::link_evt_t evt_o
);

  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  logic scl_rise, scl_fall, start_c, stop_c;
  comp_pkg::link_state_t state, next_state;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [7:0] shreg, next_shreg, tx_sh, next_tx_sh;
  logic is_addr, next_is_addr, rw, next_rw, drive, next_drive;
  logic master_ack, next_master_ack;
  comp_pkg::link_evt_t evt, next_evt;

  // three flops on each pin; edge logic compares the second stage with the third
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d} <= 6'h3f;
    end else begin
      {scl_s1, scl_s2, scl_d} <= {scl_i, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_d} <= {sda_i, sda_s1, sda_s2};
    end
  end

  assign scl_rise = scl_s2 & ~scl_d;
  assign scl_fall = ~scl_s2 & scl_d;
  assign start_c = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_c = scl_s2 & scl_d & ~sda_d & sda_s2;

  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_tx_sh = tx_sh;
    next_is_addr = is_addr;
    next_rw = rw;
    next_drive = drive;
    next_master_ack = master_ack;
    next_evt = '0;
    next_evt.rx_byte = evt.rx_byte;
    if (start_c) begin
      next_state = comp_pkg::L_RX;
      next_is_addr = 1'b1;
      next_rw = 1'b0;
      next_bit_cnt = 3'h0;
      next_drive = 1'b0;
      next_evt.start = 1'b1;
    end else if (stop_c) begin
      next_state = comp_pkg::L_IDLE;
      next_drive = 1'b0;
      next_evt.stop = 1'b1;
    end else begin
      case (state)
        comp_pkg::L_RX: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sda_s2};
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
              next_state = comp_pkg::L_RX_END;
            end
          end
        end
        comp_pkg::L_RX_END: begin
          if (scl_fall) begin
            if (!is_addr) begin
              next_drive = 1'b1;
              next_evt.rx_valid = 1'b1;
              next_evt.rx_byte = shreg;
              next_state = comp_pkg::L_RX_ACK;
            end else if (shreg[7:1] == ADDR && accept_i && (!shreg[0] || read_ok_i)) begin
              next_drive = 1'b1;
              next_rw = shreg[0];
              next_evt.addr = 1'b1;
              next_evt.rw = shreg[0];
              next_state = comp_pkg::L_RX_ACK;
            end else begin
              // not ours or refused: stay off the bus until the next start
              next_state = comp_pkg::L_IDLE;
            end
          end
        end
        comp_pkg::L_RX_ACK: begin
          if (scl_fall) begin
            next_bit_cnt = 3'h0;
            next_is_addr = 1'b0;
            if (rw) begin
              next_tx_sh = tx_byte_i;
              next_drive = ~tx_byte_i[7];
              next_evt.tx_req = 1'b1;
              next_state = comp_pkg::L_TX;
            end else begin
              next_drive = 1'b0;
              next_state = comp_pkg::L_RX;
            end
          end
        end
        comp_pkg::L_TX: begin
          if (scl_fall) begin
            if (bit_cnt == 3'h7) begin
              next_drive = 1'b0;
              next_state = comp_pkg::L_TX_ACK;
            end else begin
              next_tx_sh = {tx_sh[6:0], 1'b0};
              next_drive = ~tx_sh[6];
              next_bit_cnt = bit_cnt + 3'h1;
            end
          end
        end
        comp_pkg::L_TX_ACK: begin
          if (scl_rise) begin
            next_master_ack = ~sda_s2;
          end else if (scl_fall) begin
            next_bit_cnt = 3'h0;
            if (master_ack) begin
              next_tx_sh = tx_byte_i;
              next_drive = ~tx_byte_i[7];
              next_evt.tx_req = 1'b1;
              next_state = comp_pkg::L_TX;
            end else begin
              next_state = comp_pkg::L_IDLE;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= comp_pkg::L_IDLE;
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
      tx_sh <= 8'h00;
      is_addr <= 1'b0;
      rw <= 1'b0;
      drive <= 1'b0;
      master_ack <= 1'b0;
      evt <= '0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      tx_sh <= next_tx_sh;
      is_addr <= next_is_addr;
      rw <= next_rw;
      drive <= next_drive;
      master_ack <= next_master_ack;
      evt <= next_evt;
    end
  end

  assign sda_oe_n_o = ~drive;
  assign evt_o = evt;

endmodule // i2c_byte_target

// ==== sim/comp_asserts.sv ====
`timescale 1ns/1ps
`include "comp_consts.svh"
module comp_asserts (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic [5:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic SCL_I,
  input wire logic SDA_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_N_O
);
  logic used;
  logic co2_ok;
  logic [15:0] co2;
  wire rack = AVS_READ_I && !AVS_WAITREQUEST_O;
  wire wack = AVS_WRITE_I && !AVS_WAITREQUEST_O;
  wire [5:0] a = AVS_ADDRESS_I;
  // any low on the data line means the link may have changed settings
  always_ff @(posedge CLK_I) begin
    used <= !RESET_I && (used || !SDA_I);
    co2_ok <= !RESET_I && (co2_ok || (wack && a == `REG_CO2));
    if (wack && a == `REG_CO2) begin
      co2 <= AVS_WRITEDATA_I[15:0];
    end
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  a_off_reset: assert property (
    rack && !used && a == `REG_TOFFSET |-> AVS_READDATA_O == 32'h0000_05da)
    else $error("offset default wrong");
  a_alt_reset: assert property (
    rack && !used && a == `REG_ALT |-> AVS_READDATA_O == 32'h0)
    else $error("altitude default wrong");
  a_comp_reset: assert property (
    rack && !used && a == `REG_COMP |-> AVS_READDATA_O == 32'h0)
    else $error("compensation source wrong at reset");
  a_status_idle: assert property (
    rack && !used && a == `REG_STATUS |-> AVS_READDATA_O == 32'h0)
    else $error("status not idle at reset");
  a_word_upper: assert property (
    rack && (a == `REG_TOFFSET || a == `REG_ALT || a == `REG_PRESS)
    |-> AVS_READDATA_O[31:16] == 16'h0)
    else $error("setting word too wide");
  a_co2_kept: assert property (
    rack && co2_ok && a == `REG_CO2 |-> AVS_READDATA_O == {16'h0, co2})
    else $error("gas word altered");
  a_sda_hold: assert property (
    $fell(SDA_OE_N_O) |-> (!SDA_OE_N_O) [*4])
    else $error("data pull too short");
  a_sda_free: assert property (
    !SDA_OE_N_O |-> ##[0:100] SDA_OE_N_O)
    else $error("data line held too long");
  a_sda_pull_low: assert property (
    !SDA_OE_N_O |-> !SDA_O)
    else $error("data line driven high");
  cover property (rack && a == `REG_COMP && AVS_READDATA_O[16]);
  cover property ($fell(SDA_OE_N_O));
  cover property (rack && co2_ok && a == `REG_CO2);
endmodule // comp_asserts

// ==== sim/i2c_host.sv ====
`timescale 1ns/1ps
module i2c_host (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic pull_o
);
  // clock idles high between frames
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end
  task automatic q;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic bitx(input logic b, output logic r);
    scl_o <= 1'b0;
    q();
    pull_o <= !b;
    q();
    scl_o <= 1'b1;
    q();
    r = sda_i;
    q();
  endtask
  task automatic start;
    pull_o <= 1'b1;
    q();
  endtask
  task automatic stop;
    scl_o <= 1'b0;
    q();
    pull_o <= 1'b1;
    q();
    scl_o <= 1'b1;
    q();
    pull_o <= 1'b0;
    q();
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  task automatic rd(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(last, r);
  endtask
endmodule // i2c_host

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
`include "comp_consts.svh"
module tb_top;
  logic clk, rst, rd, wr, pull, scl, wreq, oe_n, sda, ok;
  logic [5:0] adr;
  logic [31:0] wdat, rdat, seed;
  int mismatches, checks_done;
  // released line floats to the pull-up
  assign sda = !(pull || !oe_n);
  compensation_settings_cmds #(.STOP_CYCLES(200), .PERIOD_CYCLES(300)) u_compensation_settings_cmds (
    .CLK_I(clk), .RESET_I(rst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wdat), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq),
    .SCL_I(scl), .SDA_I(sda), .SDA_O(), .SDA_OE_N_O(oe_n));
  i2c_host host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .pull_o(pull));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [7:0] crc(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
    return c;
  endfunction
  function automatic logic [31:0] trh(input logic [15:0] t, h, o);
    logic [16:0] s;
    s = {1'b0, h} + {1'b0, o};
    return {s[16] ? 16'hffff : s[15:0], t > o ? t - o : 16'h0};
  endfunction
  task chk(input logic [31:0] g, e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    logic done;
    done = 1'b0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    // wait state, read data and release all belong to one rising edge
    for (int n = 0; n < 20 && !done; n++) begin
      @(posedge clk);
      done = (wreq === 1'b0);
      q = rdat;
    end
    rd <= 1'b0;
    wr <= 1'b0;
    if (!done) begin
      chk(32'h0, 32'h1);
      final_report();
    end
  endtask
  task wreg(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task rchk(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task poll(input int b, input logic v);
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      bus(1'b0, `REG_STATUS, 32'h0, q);
      n++;
    end while (q[b] !== v && n < 200);
    chk({31'h0, q[b]}, {31'h0, v});
    if (q[b] !== v) final_report();
  endtask
  task cmd(input logic [15:0] c, input logic p, input logic [15:0] w, input logic [7:0] k);
    logic a;
    host.start();
    host.wr(8'h54, ok);
    host.wr(c[15:8], a);
    host.wr(c[7:0], a);
    if (p) begin
      host.wr(w[15:8], a);
      host.wr(w[7:0], a);
      host.wr(k, a);
    end
    host.stop();
  endtask
  task getchk(input logic [15:0] c, input logic [15:0] e);
    logic [15:0] w;
    logic [7:0] k;
    logic a;
    cmd(c, 1'b0, 16'h0, 8'h0);
    host.start();
    host.wr(8'h55, a);
    host.rd(1'b0, w[15:8]);
    host.rd(1'b0, w[7:0]);
    host.rd(1'b1, k);
    host.stop();
    chk({a, k, w}, {1'b1, crc(e), e});
  endtask
  task do_reset;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  initial begin
    logic [15:0] v, t, h;
    rst = 1'b1;
    {rd, wr, adr, wdat, mismatches, checks_done} = '0;
    seed = 32'hbdea;
    do_reset();
    rchk(`REG_TOFFSET, 32'h0000_05da);
    rchk(`REG_ALT, 32'h0);
    rchk(`REG_COMP, 32'h0);
    rchk(`REG_STATUS, 32'h0);
    wreg(6'h24, 32'hffff_ffff);
    rchk(6'h24, 32'h0);
    chk(crc(16'h07e6), 32'h48);
    getchk(`CMD_GET_TOFFSET, 16'h05da);
    cmd(`CMD_SET_TOFFSET, 1'b1, 16'h07e6, 8'h48);
    rchk(`REG_TOFFSET, 32'h0000_07e6);
    getchk(`CMD_GET_TOFFSET, 16'h07e6);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      v = (i == 0) ? 16'hffff : seed[15:0];
      cmd(`CMD_SET_ALT, 1'b1, v, crc(v));
      getchk(`CMD_GET_ALT, v);
      rchk(`REG_COMP, {16'h0, v});
    end
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      t = (i == 0) ? 16'h0003 : seed[15:0];
      h = (i == 0) ? 16'hfff0 : seed[31:16];
      wreg(`REG_RAW_T, {16'h0, t});
      wreg(`REG_RAW_RH, {16'h0, h});
      wreg(`REG_CO2, {16'h0, t ^ h});
      rchk(`REG_OUT_TRH, trh(t, h, 16'h07e6));
      rchk(`REG_CO2, {16'h0, t ^ h});
    end
    cmd(`CMD_START_MEAS, 1'b0, 16'h0, 8'h0);
    poll(`ST_MEAS, 1'b1);
    cmd(`CMD_SET_TOFFSET, 1'b1, 16'h0100, crc(16'h0100));
    rchk(`REG_TOFFSET, 32'h0000_07e6);
    cmd(`CMD_SET_PRESS, 1'b1, 16'h03db, 8'h42);
    rchk(`REG_PRESS, 32'h0000_03db);
    rchk(`REG_COMP, 32'h0001_03db);
    poll(`ST_REFRESH, 1'b1);
    cmd(`CMD_STOP_MEAS, 1'b0, 16'h0, 8'h0);
    poll(`ST_STOP_BUSY, 1'b1);
    cmd(`CMD_GET_ALT, 1'b0, 16'h0, 8'h0);
    chk({31'h0, ok}, 32'h0);
    // wait out the hold-off before settings
    poll(`ST_STOP_BUSY, 1'b0);
    poll(`ST_MEAS, 1'b0);
    cmd(`CMD_SET_ALT, 1'b1, 16'h079e, 8'h09);
    rchk(`REG_ALT, 32'h0000_079e);
    rchk(`REG_COMP, 32'h0001_03db);
    cmd(`CMD_SET_ALT, 1'b1, 16'h044c, 8'h43);
    rchk(`REG_ALT, 32'h0000_079e);
    poll(`ST_CRC_ERR, 1'b1);
    wreg(`REG_STATUS, 32'h10);
    poll(`ST_CRC_ERR, 1'b0);
    do_reset();
    rchk(`REG_TOFFSET, 32'h0000_05da);
    rchk(`REG_COMP, 32'h0);
    final_report();
  end
endmodule // tb_top
bind compensation_settings_cmds comp_asserts u_comp_asserts (.*);
